/* File: jtbs_tap.sv */
// Boundary-scan test access port, oversampling the test clock on CLK
`timescale 1ns/1ps
module jtbs_tap import jtbs_pkg::*; #(
  parameter int BSR_LEN = 420,
  parameter bit HAS_BSCAN = 1'b1,
  parameter int ANA_W = 16,
  parameter logic [ID_VER_W-1:0] ID_VERSION = 4'h1,     // Arbitrary value
  parameter logic [ID_PART_W-1:0] ID_PART = 16'h5A3C,   // Arbitrary value
  parameter logic [ID_MFR_W-1:0] ID_MFR = 11'h2B5,      // Arbitrary value
  parameter logic [ID_LEN-1:0] USERCODE = 32'h0000_0000
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial test pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  // Boundary cells
  input wire logic [BSR_LEN-1:0] PIN_IN,
  output logic [BSR_LEN-1:0] PIN_OUT,
  output logic PIN_TEST_MODE,
  // Configuration engine
  input wire logic CFG_BUSY,
  output logic CFG_BIT,
  output logic CFG_STROBE,
  // Embedded analyser
  input wire logic [ANA_W-1:0] ANA_PROBE,
  output logic [ANA_W-1:0] ANA_CTRL,
  output logic ANA_UPDATE
);

  localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR,
                                           ID_LSB};

  logic tck_s, tms_s, tdi_s, tck_prev_q, rise, fall;
  logic [BSR_LEN-1:0] pin_s, bsr_q, pin_out_q;
  jtbs_state_t state_q, state_d;
  jtbs_op_t op;
  logic [IR_LEN-1:0] ir_q, irsh_q;
  logic [ID_LEN-1:0] dr32_q;
  logic [ANA_W-1:0] ana_q, ana_ctrl_q;
  logic byp_q, tdo_q, tdo_oe_q, test_mode_q, cfg_bit_q, cfg_stb_q, ana_upd_q;
  logic [2:0] tms1_cnt_q;

  // One synchroniser for all pin inputs keeps their delays equal
  jtbs_sync #(.W(BSR_LEN + 3)) u_sync (
    .CLK(CLK), .RST(RST),
    .D({TCK, TMS, TDI, PIN_IN}),
    .Q({tck_s, tms_s, tdi_s, pin_s})
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  assign rise = tck_s & ~tck_prev_q;
  assign fall = ~tck_s & tck_prev_q;

  function automatic jtbs_state_t tap_next(input jtbs_state_t s,
                                           input logic m);
    case (s)
      TLR: return m ? TLR : RTI;
      RTI: return m ? SEL_DR : RTI;
      SEL_DR: return m ? SEL_IR : CAP_DR;
      CAP_DR: return m ? EX1_DR : SH_DR;
      SH_DR: return m ? EX1_DR : SH_DR;
      EX1_DR: return m ? UP_DR : PA_DR;
      PA_DR: return m ? EX2_DR : PA_DR;
      EX2_DR: return m ? UP_DR : SH_DR;
      UP_DR: return m ? SEL_DR : RTI;
      SEL_IR: return m ? TLR : CAP_IR;
      CAP_IR: return m ? EX1_IR : SH_IR;
      SH_IR: return m ? EX1_IR : SH_IR;
      EX1_IR: return m ? UP_IR : PA_IR;
      PA_IR: return m ? EX2_IR : PA_IR;
      EX2_IR: return m ? UP_IR : SH_IR;
      UP_IR: return m ? SEL_DR : RTI;
      default: return TLR;
    endcase
  endfunction
  // Unsupported or blocked codes fall back to bypass, so a chain
  // stays intact whatever the host loads
  function automatic jtbs_op_t op_of(input logic [IR_LEN-1:0] ir,
                                     input logic busy);
    case (ir)
      IR_ANA_ACCESS: return OP_ANA;
      IR_IDCODE: return HAS_BSCAN ? OP_IDCODE : OP_BYP;
      IR_USERCODE: return HAS_BSCAN ? OP_USER : OP_BYP;
      IR_CFG_PROGRAM: return HAS_BSCAN ? OP_CFG : OP_BYP;
      IR_SAMPLE: return (HAS_BSCAN && !busy) ? OP_SAMPLE : OP_BYP;
      IR_EXTEST: return (HAS_BSCAN && !busy) ? OP_EXTEST : OP_BYP;
      default: return OP_BYP;
    endcase
  endfunction
  assign state_d = tap_next(state_q, tms_s);
  assign op = op_of(ir_q, CFG_BUSY);

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= TLR;
    end else if (rise) begin
      state_q <= state_d;
    end
  end

  // Instruction path
  always_ff @(posedge CLK) begin
    if (RST) begin
      irsh_q <= IR_CAPTURE;
      ir_q <= IR_IDCODE;
    end else if (state_q == TLR) begin
      ir_q <= IR_IDCODE;
    end else if (rise) begin
      case (state_q)
        CAP_IR: irsh_q <= IR_CAPTURE;
        SH_IR: irsh_q <= {tdi_s, irsh_q[IR_LEN-1:1]};
        UP_IR: ir_q <= irsh_q;
        default: irsh_q <= irsh_q;
      endcase
    end
  end

  // Bypass stage, also the one-bit path while configuration data flows
  always_ff @(posedge CLK) begin
    if (RST) begin
      byp_q <= BYP_CAPTURE;
    end else if (rise && (op == OP_BYP || op == OP_CFG)) begin
      if (state_q == CAP_DR) begin
        byp_q <= BYP_CAPTURE;
      end else if (state_q == SH_DR) begin
        byp_q <= tdi_s;
      end
    end
  end

  // Identification and user code share one 32-bit shifter
  always_ff @(posedge CLK) begin
    if (RST) begin
      dr32_q <= '0;
    end else if (rise && (op == OP_IDCODE || op == OP_USER)) begin
      if (state_q == CAP_DR) begin
        dr32_q <= (op == OP_IDCODE) ? ID_WORD : USERCODE;
      end else if (state_q == SH_DR) begin
        dr32_q <= {tdi_s, dr32_q[ID_LEN-1:1]};
      end
    end
  end

  // Boundary register; the extra top bit keeps a one-cell chain legal
  logic [BSR_LEN:0] bsr_ext;
  assign bsr_ext = {tdi_s, bsr_q};
  always_ff @(posedge CLK) begin
    if (RST) begin
      bsr_q <= '0;
      pin_out_q <= '0;
    end else if (rise && (op == OP_SAMPLE || op == OP_EXTEST)) begin
      case (state_q)
        CAP_DR: bsr_q <= pin_s;
        SH_DR: bsr_q <= bsr_ext[BSR_LEN:1];
        UP_DR: pin_out_q <= bsr_q;
        default: bsr_q <= bsr_q;
      endcase
    end
  end

  // Pins follow the update stage only under external test
  always_ff @(posedge CLK) begin
    if (RST) begin
      test_mode_q <= 1'b0;
    end else begin
      test_mode_q <= (op == OP_EXTEST);
    end
  end

  // Analyser access: capture probes at full speed, update controls
  logic [ANA_W:0] ana_ext;
  assign ana_ext = {tdi_s, ana_q};
  always_ff @(posedge CLK) begin
    if (RST) begin
      ana_q <= '0;
      ana_ctrl_q <= '0;
      ana_upd_q <= 1'b0;
    end else begin
      ana_upd_q <= 1'b0;
      if (rise && op == OP_ANA) begin
        case (state_q)
          CAP_DR: ana_q <= ANA_PROBE;
          SH_DR: ana_q <= ana_ext[ANA_W:1];
          UP_DR: begin
            ana_ctrl_q <= ana_q;
            ana_upd_q <= 1'b1;
          end
          default: ana_q <= ana_q;
        endcase
      end
    end
  end

  // Configuration stream: one strobe per shifted bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_bit_q <= 1'b0;
      cfg_stb_q <= 1'b0;
    end else begin
      cfg_stb_q <= 1'b0;
      if (rise && state_q == SH_DR && op == OP_CFG) begin
        cfg_bit_q <= tdi_s;
        cfg_stb_q <= 1'b1;
      end
    end
  end

  // Serial output changes on the falling test clock edge
  logic sel_bit;
  always_comb begin
    sel_bit = byp_q;
    case (op)
      OP_IDCODE, OP_USER: sel_bit = dr32_q[0];
      OP_SAMPLE, OP_EXTEST: sel_bit = bsr_q[0];
      OP_ANA: sel_bit = ana_q[0];
      default: sel_bit = byp_q;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (fall) begin
      tdo_oe_q <= (state_q == SH_DR) || (state_q == SH_IR);
      if (state_q == SH_IR) begin
        tdo_q <= irsh_q[0];
      end else if (state_q == SH_DR) begin
        tdo_q <= sel_bit;
      end else begin
        tdo_q <= 1'b0;
      end
    end
  end

  assign TDO = tdo_q;
  assign TDO_OE = tdo_oe_q;
  assign PIN_OUT = pin_out_q;
  assign PIN_TEST_MODE = test_mode_q;
  assign CFG_BIT = cfg_bit_q;
  assign CFG_STROBE = cfg_stb_q;
  assign ANA_CTRL = ana_ctrl_q;
  assign ANA_UPDATE = ana_upd_q;

  // Helper: run of consecutive TMS-high test clock rises
  always_ff @(posedge CLK) begin
    if (RST) begin
      tms1_cnt_q <= 3'h0;
    end else if (rise) begin
      if (!tms_s) begin
        tms1_cnt_q <= 3'h0;
      end else if (tms1_cnt_q != TMS_RESET_RUN) begin
        tms1_cnt_q <= tms1_cnt_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_cap_dr(jtbs_op_t k);
    rise && state_q == CAP_DR && op == k;
  endsequence
  sequence s_shift_dr(jtbs_op_t k);
    rise && state_q == SH_DR && op == k;
  endsequence
  tms_reset_a: assert property (
    tms1_cnt_q == TMS_RESET_RUN |-> state_q == TLR)
    else $error("five TMS-high clocks did not reach reset state");
  tdo_enable_a: assert property (
    fall && (state_q == SH_DR || state_q == SH_IR) |=> TDO_OE)
    else $error("TDO not enabled in a shift state");
  reset_idcode_a: assert property (
    state_q == TLR |=> ir_q == IR_IDCODE)
    else $error("reset state did not select identification");
  ir_capture_a: assert property (
    rise && state_q == CAP_IR |=> irsh_q[1:0] == 2'b01)
    else $error("instruction capture pattern wrong");
  ir_update_a: assert property (
    rise && state_q == UP_IR |=> ir_q == $past(irsh_q))
    else $error("instruction not loaded from ten-bit shifter");
  bypass_delay_a: assert property (
    s_shift_dr(OP_BYP) |=> byp_q == $past(tdi_s))
    else $error("bypass stage did not take TDI");
  id_capture_a: assert property (
    s_cap_dr(OP_IDCODE) |=> dr32_q == ID_WORD && dr32_q[0] == ID_LSB)
    else $error("identification word not captured");
  user_capture_a: assert property (
    s_cap_dr(OP_USER) |=> dr32_q == USERCODE)
    else $error("user code not captured");
  sample_pins_a: assert property (
    s_cap_dr(OP_SAMPLE) |=> bsr_q == $past(pin_s))
    else $error("sample did not snapshot the pins");
  extest_mode_a: assert property (
    op == OP_EXTEST |=> PIN_TEST_MODE)
    else $error("external test did not take the pins");
  cfg_block_a: assert property (
    CFG_BUSY |=> !PIN_TEST_MODE)
    else $error("boundary test active during configuration");
  no_bscan_a: assert property (
    !HAS_BSCAN |-> !PIN_TEST_MODE && op != OP_CFG)
    else $error("variant without boundary scan used it");
  cfg_strobe_a: assert property (
    s_shift_dr(OP_CFG) |=> CFG_STROBE && CFG_BIT == $past(tdi_s) ##1
    !CFG_STROBE)
    else $error("configuration bit not strobed once");
  ana_capture_a: assert property (
    s_cap_dr(OP_ANA) |=> ana_q == $past(ANA_PROBE))
    else $error("analyser probes not captured");
endmodule

/* File: jtbs_pkg.sv */
// Shared constants and types for the boundary-scan test access port
package jtbs_pkg;

  // Instruction register
  localparam int IR_LEN = 10;
  localparam logic [IR_LEN-1:0] IR_EXTEST = 10'h000;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
  localparam logic [IR_LEN-1:0] IR_CFG_PROGRAM = 10'h002;
  localparam logic [IR_LEN-1:0] IR_SAMPLE = 10'h005;
  localparam logic [IR_LEN-1:0] IR_IDCODE = 10'h006;
  localparam logic [IR_LEN-1:0] IR_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] IR_ANA_ACCESS = 10'h00E;
  localparam logic [IR_LEN-1:0] IR_BYPASS = 10'h3FF;

  // Identification word layout, MSB first
  localparam int ID_LEN = 32;
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_W = 11;
  localparam logic ID_LSB = 1'b1;

  // Reset values
  localparam logic BYP_CAPTURE = 1'b0;

  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
    EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UP_IR = 4'hF
  } jtbs_state_t;

  typedef enum logic [2:0] {
    OP_BYP = 3'h0, OP_SAMPLE = 3'h1, OP_EXTEST = 3'h2, OP_IDCODE = 3'h3,
    OP_USER = 3'h4, OP_CFG = 3'h5, OP_ANA = 3'h6
  } jtbs_op_t;

  // Saturation point of the consecutive TMS-high counter
  localparam logic [2:0] TMS_RESET_RUN = 3'h5;

endpackage

/* File: jtbs_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module jtbs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  // First stage is read only by the second stage
  logic [W-1:0] meta_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_q <= '0;
      Q <= '0;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end

endmodule

/* File: jtbs_host.sv */
// Test host model: drives the serial test pins and reads TDO
`timescale 1ns/1ps
module jtbs_host (
  // Serial test pins
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input wire logic TDO
);
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // Pins move in the low phase and TDO is read halfway through the high phase,
  // because the port answers some CLK cycles after each fall
  task automatic tick(input logic ms, input logic di, output logic d);
    TMS = ms;
    TDI = di;
    #80 TCK = 1'b1;
    #40 d = TDO;
    #40 TCK = 1'b0;
  endtask
  task automatic run(input int n, input logic ms);
    logic d;
    for (int i = 0; i < n; i++) tick(ms, ~TDI, d);
  endtask
  // One scan from Run-Test/Idle back to it; the clock then stands low
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
                      output logic [63:0] q);
    logic d;
    q = '0;
    tick(1'b1, ~TDI, d);
    if (ir) tick(1'b1, ~TDI, d);
    tick(1'b0, ~TDI, d);
    tick(1'b0, ~TDI, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      q[i] = d;
    end
    tick(1'b1, ~TDI, d);
    tick(1'b0, ~TDI, d);
  endtask
endmodule

/* File: tb_jtbs_tap.sv */
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
module tb_jtbs_tap;
  import jtbs_pkg::*;
  localparam int BL = 8;
  localparam logic [31:0] ID_EXP = {4'h3, 16'h1B2D, 11'h0A5, 1'b1};
  localparam logic [31:0] UC = 32'hC0DE_1234;
  // Test clock period of the host in CLK cycles
  localparam int TCK_CLKS = 8;
  logic CLK, RST, TCK, TMS, TDI, TDO, TDO_OE, PIN_TEST_MODE;
  logic CFG_BUSY, CFG_BIT, CFG_STROBE, ANA_UPDATE;
  logic [BL-1:0] PIN_IN, PIN_OUT;
  logic [15:0] ANA_PROBE, ANA_CTRL;
  logic [63:0] dout, din, got;
  logic [IR_LEN-1:0] bcode [2] = '{IR_BYPASS, 10'h155};
  int err_total = 0;
  int checked = 0;
  int upd = 0;
  logic cfg_q[$];
  logic ptm_m, cstb_m;
  logic [15:0] actl_m;
  int oe_n = 0;
  int bad_m = 0;

  jtbs_tap #(.BSR_LEN(BL), .HAS_BSCAN(1'b1), .ANA_W(16),
    .ID_VERSION(4'h3), .ID_PART(16'h1B2D), .ID_MFR(11'h0A5),
    .USERCODE(UC)) uut (
    .CLK(CLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
    .TDO_OE(TDO_OE), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_TEST_MODE(PIN_TEST_MODE), .CFG_BUSY(CFG_BUSY), .CFG_BIT(CFG_BIT),
    .CFG_STROBE(CFG_STROBE), .ANA_PROBE(ANA_PROBE), .ANA_CTRL(ANA_CTRL),
    .ANA_UPDATE(ANA_UPDATE));
  // Variant without boundary scan: one cell, bypass and analyser only
  jtbs_tap #(.BSR_LEN(1), .HAS_BSCAN(1'b0), .ANA_W(16)) uut_min (
    .CLK(CLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(),
    .TDO_OE(), .PIN_IN(PIN_IN[0]), .PIN_OUT(), .PIN_TEST_MODE(ptm_m),
    .CFG_BUSY(CFG_BUSY), .CFG_BIT(), .CFG_STROBE(cstb_m),
    .ANA_PROBE(ANA_PROBE), .ANA_CTRL(actl_m), .ANA_UPDATE());
  jtbs_host host (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // Strobes are single CLK pulses, so they are collected on every edge
  always @(posedge CLK) begin
    if (CFG_STROBE === 1'b1) cfg_q.push_back(CFG_BIT);
    if (ANA_UPDATE === 1'b1) upd++;
    if (TDO_OE === 1'b1) oe_n++;
    if (ptm_m === 1'b1 || cstb_m === 1'b1) bad_m++;
  end

  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk_ser(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: serial %h, expected %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic [BL-1:0] g, input logic [BL-1:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: pins %h, expected %h", $time, g, e);
    end
  endtask

  task automatic load_ir(input logic [IR_LEN-1:0] code);
    oe_n = 0;
    host.scan(1'b1, IR_LEN, 64'(code), dout);
    chk_ser(dout, 64'h1);
    chk_ser(64'(oe_n), 64'(TCK_CLKS * IR_LEN));
  endtask

  initial begin
    #400_000;
    err_total++;
    $display("ERROR %0t: run timed out", $time);
    test_done();
  end

  initial begin
    RST = 1'b1;
    PIN_IN = '0;
    CFG_BUSY = 1'b0;
    ANA_PROBE = '0;
    void'($urandom(32'h764d));
    repeat (12) @(posedge CLK);
    @(negedge CLK) RST = 1'b0;
    repeat (4) @(negedge CLK);
    host.run(1, 1'b0);
    host.scan(1'b0, ID_LEN, 64'h0, dout);
    chk_ser(dout, 64'(ID_EXP));
    $display("done: identification after reset");

    load_ir(IR_USERCODE);
    host.scan(1'b0, 32, {$urandom, $urandom}, dout);
    chk_ser(dout, 64'(UC));
    $display("done: user code");

    // Listed bypass code and an unlisted one both give a one-stage path
    for (int k = 0; k < 2; k++) begin
      load_ir(bcode[k]);
      din = {$urandom, $urandom};
      host.scan(1'b0, 20, din, dout);
      chk_ser(dout, {44'h0, din[18:0], BYP_CAPTURE});
    end
    $display("done: bypass");

    for (int k = 0; k < 2; k++) begin
      @(negedge CLK) PIN_IN = BL'($urandom);
      load_ir(k ? IR_EXTEST : IR_SAMPLE);
      din = 64'($urandom);
      host.scan(1'b0, BL, din, dout);
      chk_ser(dout, 64'(PIN_IN));
      chk_pin(PIN_OUT, din[BL-1:0]);
      chk_pin(BL'(PIN_TEST_MODE), BL'(k));
    end
    $display("done: sample and external test");

    // Configuration running: the loaded external test turns to bypass
    @(negedge CLK) CFG_BUSY = 1'b1;
    repeat (3) @(negedge CLK);
    chk_pin(BL'(PIN_TEST_MODE), '0);
    got = din;
    din = {$urandom, $urandom};
    host.scan(1'b0, BL + 1, din, dout);
    chk_ser(dout, {55'h0, din[BL-1:0], 1'b0});
    chk_pin(PIN_OUT, got[BL-1:0]);
    @(negedge CLK) CFG_BUSY = 1'b0;
    $display("done: boundary test refused while configuring");

    load_ir(IR_CFG_PROGRAM);
    cfg_q.delete();
    din = 64'($urandom);
    host.scan(1'b0, 16, din, dout);
    got = '0;
    foreach (cfg_q[i]) got[i] = cfg_q[i];
    chk_ser(64'(cfg_q.size()), 64'd16);
    chk_ser(got, {48'h0, din[15:0]});
    chk_ser(dout, {48'h0, din[14:0], 1'b0});
    chk_ser(64'(bad_m), 64'd0);
    $display("done: configuration load");

    @(negedge CLK) ANA_PROBE = 16'($urandom);
    load_ir(IR_ANA_ACCESS);
    upd = 0;
    din = 64'($urandom);
    host.scan(1'b0, 16, din, dout);
    chk_ser(dout, 64'(ANA_PROBE));
    chk_ser(64'(ANA_CTRL), {48'h0, din[15:0]});
    chk_ser(64'(upd), 64'd1);
    chk_ser(64'(actl_m), {48'h0, din[15:0]});
    $display("done: analyser access");

    // Five mode-high clocks reset the port and reselect identification
    load_ir(IR_USERCODE);
    host.run(5, 1'b1);
    host.run(1, 1'b0);
    host.scan(1'b0, ID_LEN, 64'h0, dout);
    chk_ser(dout, 64'(ID_EXP));
    $display("done: port reset by mode select");
    test_done();
  end
endmodule
